//--- adcc_top.sv
// Register access over AXI4-Lite and the placing of the registers were decided locally.
`timescale 1ns/1ps
`default_nettype none

module adcc_top (
  // Clock and reset
  input wire logic MCLK_I,
  input wire logic RESET_I,
  // AXI4-Lite write address and data
  input wire logic AXI_AWVALID_I,
  output logic AXI_AWREADY_O,
  input wire logic [3:0] AXI_AWADDR_I,
  input wire logic AXI_WVALID_I,
  output logic AXI_WREADY_O,
  input wire logic [31:0] AXI_WDATA_I,
  input wire logic [3:0] AXI_WSTRB_I,
  // AXI4-Lite write response
  output logic AXI_BVALID_O,
  input wire logic AXI_BREADY_I,
  output logic [1:0] AXI_BRESP_O,
  // AXI4-Lite read
  input wire logic AXI_ARVALID_I,
  output logic AXI_ARREADY_O,
  input wire logic [3:0] AXI_ARADDR_I,
  output logic AXI_RVALID_O,
  input wire logic AXI_RREADY_I,
  output logic [31:0] AXI_RDATA_O,
  output logic [1:0] AXI_RRESP_O,
  // Pins
  input wire logic ACLK_SRC_I,
  input wire logic ALTCLK_SRC_I,
  input wire logic HW_TRIGGER_I,
  input wire logic STOP_MODE_I,
  // Analog core
  input wire logic [9:0] CORE_RESULT_I,
  output logic [4:0] CORE_CHANNEL_O,
  output logic CORE_POWER_O,
  output logic CORE_START_O,
  // Interrupt
  output logic IRQ_O
);
  import adcc_pkg::*;

  typedef struct packed {
    logic [4:0] channel_select;
    logic continuous_enable;
    logic complete_irq_enable;
    logic conversion_complete_flag;
    logic irq;
    logic [1:0] clock_divide;
    logic input_clock_select;
    logic long_sample_select;
    logic mode10;
    logic async_clock_enable;
    logic hw_trigger_select;
    logic [1:0] result_high;
    logic [7:0] result_low;
    logic high_read;
    adcc_state_t state;
    logic first;
    logic [9:0] cnt;
    logic start;
    logic trig_prev;
    logic aw_hold;
    logic [3:0] aw_addr;
    logic w_hold;
    logic [7:0] w_data;
    logic w_lane0;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [7:0] rdata;
    logic [1:0] rresp;
  } adcc_top_t;

  adcc_top_t r_reg;
  adcc_top_t r_next;

  logic aclk_s;
  logic altclk_s;
  logic trig_s;
  logic stop_s;
  logic [9:0] core_s;
  logic ck_tick;
  logic wr_fire;
  logic wr_ctrl;
  logic wr_clk;
  logic abort_now;
  logic blocked;
  logic [8:0] round_sum;
  logic [7:0] round8;
  logic [5:0] budget;

  // The core result is only read at transfer, long after it settled.
  adcc_sync2 #(.WIDTH(14)) u_sync (
    .clk_i(MCLK_I),
    .rst_i(RESET_I),
    .d_i({ACLK_SRC_I, ALTCLK_SRC_I, HW_TRIGGER_I, STOP_MODE_I, CORE_RESULT_I}),
    .q_o({aclk_s, altclk_s, trig_s, stop_s, core_s})
  );

  adcc_clkgen u_clkgen (
    .clk_i(MCLK_I),
    .rst_i(RESET_I),
    .enable_i(r_reg.state == ST_CONV),
    .async_en_i(r_reg.async_clock_enable),
    .ics_i(r_reg.input_clock_select),
    .div_i(r_reg.clock_divide),
    .aclk_i(aclk_s),
    .altclk_i(altclk_s),
    .tick_o(ck_tick)
  );

  function automatic logic [5:0] pick_budget(input logic m10, input logic lsmp,
                                             input logic first);
    logic [5:0] b;
    case ({m10, lsmp})
      2'b00: b = first ? CCK_S8_FIRST : CCK_S8_NEXT;
      2'b01: b = first ? CCK_L8_FIRST : CCK_L8_NEXT;
      2'b10: b = first ? CCK_S10_FIRST : CCK_S10_NEXT;
      default: b = first ? CCK_L10_FIRST : CCK_L10_NEXT;
    endcase
    return b;
  endfunction

  assign AXI_AWREADY_O = !r_reg.aw_hold;
  assign AXI_WREADY_O = !r_reg.w_hold;
  assign AXI_ARREADY_O = !r_reg.rvalid;

  always_comb begin
    r_next = r_reg;
    r_next.start = 1'b0;
    r_next.trig_prev = trig_s;
    budget = pick_budget(r_reg.mode10, r_reg.long_sample_select, r_reg.first);
    round_sum = {1'b0, core_s[9:2]} + {8'h00, core_s[1]};
    // Rounding full scale up would wrap to zero, so it saturates.
    round8 = round_sum[8] ? 8'hFF : round_sum[7:0];
    blocked = r_reg.mode10 && r_reg.high_read;

    // Write channel: address and data may arrive in either order.
    if (AXI_AWVALID_I && !r_reg.aw_hold) begin
      r_next.aw_hold = 1'b1;
      r_next.aw_addr = AXI_AWADDR_I;
    end
    if (AXI_WVALID_I && !r_reg.w_hold) begin
      r_next.w_hold = 1'b1;
      r_next.w_data = AXI_WDATA_I[7:0];
      r_next.w_lane0 = AXI_WSTRB_I[0];
    end
    wr_fire = r_reg.aw_hold && r_reg.w_hold && !r_reg.bvalid;
    wr_ctrl = wr_fire && r_reg.w_lane0 && r_reg.aw_addr == OFF_CTRL;
    wr_clk = wr_fire && r_reg.w_lane0 && r_reg.aw_addr == OFF_CLKCFG;
    if (r_reg.bvalid && AXI_BREADY_I) begin
      r_next.bvalid = 1'b0;
    end
    if (wr_fire) begin
      r_next.aw_hold = 1'b0;
      r_next.w_hold = 1'b0;
      r_next.bvalid = 1'b1;
      r_next.bresp = (r_reg.aw_addr == OFF_CTRL || r_reg.aw_addr == OFF_CLKCFG ||
                      r_reg.aw_addr == OFF_RES_HI || r_reg.aw_addr == OFF_RES_LO) ?
                     RESP_OKAY : RESP_SLVERR;
    end
    if (wr_ctrl) begin
      r_next.channel_select = r_reg.w_data[CH_LSB +: CH_W];
      r_next.continuous_enable = r_reg.w_data[CONT_BIT];
      r_next.complete_irq_enable = r_reg.w_data[IRQEN_BIT];
      r_next.conversion_complete_flag = 1'b0;
      r_next.irq = 1'b0;
    end
    if (wr_clk) begin
      r_next.clock_divide = r_reg.w_data[DIV_LSB +: 2];
      r_next.input_clock_select = r_reg.w_data[ICS_BIT];
      r_next.long_sample_select = r_reg.w_data[LSMP_BIT];
      r_next.mode10 = r_reg.w_data[MODE10_BIT];
      r_next.async_clock_enable = r_reg.w_data[ASYNC_BIT];
      r_next.hw_trigger_select = r_reg.w_data[HWTRIG_BIT];
    end

    // Read channel, with the side effects of result reads.
    if (r_reg.rvalid && AXI_RREADY_I) begin
      r_next.rvalid = 1'b0;
    end
    if (AXI_ARVALID_I && !r_reg.rvalid) begin
      r_next.rvalid = 1'b1;
      r_next.rresp = RESP_OKAY;
      case (AXI_ARADDR_I)
        OFF_CTRL: begin
          r_next.rdata = {r_reg.conversion_complete_flag, r_reg.complete_irq_enable,
                          r_reg.continuous_enable, r_reg.channel_select};
        end
        OFF_CLKCFG: begin
          r_next.rdata = {1'b0, r_reg.hw_trigger_select, r_reg.async_clock_enable,
                          r_reg.mode10, r_reg.long_sample_select,
                          r_reg.input_clock_select, r_reg.clock_divide};
        end
        OFF_RES_HI: begin
          r_next.rdata = {6'h00, r_reg.result_high};
          r_next.high_read = r_reg.mode10;
        end
        OFF_RES_LO: begin
          r_next.rdata = r_reg.result_low;
          r_next.high_read = 1'b0;
          r_next.conversion_complete_flag = 1'b0;
          r_next.irq = 1'b0;
        end
        default: begin
          r_next.rdata = 8'h00;
          r_next.rresp = RESP_SLVERR;
        end
      endcase
    end

    // Conversion sequencer; flag sets come after clears so a set wins.
    case (r_reg.state)
      ST_IDLE: begin
        if (r_reg.hw_trigger_select && trig_s && !r_reg.trig_prev &&
            r_reg.channel_select != CH_OFF) begin
          r_next.state = ST_SYNC;
          r_next.cnt = 10'h000;
          r_next.first = 1'b1;
        end
      end
      ST_SYNC: begin
        r_next.cnt = r_reg.cnt + 10'h001;
        if (r_reg.cnt == SYNC_BUS_CYC - 10'h001) begin
          r_next.cnt = 10'h000;
          if (r_reg.async_clock_enable) begin
            r_next.state = ST_START;
          end else begin
            r_next.state = ST_CONV;
            r_next.start = 1'b1;
          end
        end
      end
      ST_START: begin
        r_next.cnt = r_reg.cnt + 10'h001;
        if (r_reg.cnt == ACLK_START_CYC - 10'h001) begin
          r_next.cnt = 10'h000;
          r_next.state = ST_CONV;
          r_next.start = 1'b1;
        end
      end
      ST_CONV: begin
        if (ck_tick) begin
          r_next.cnt = r_reg.cnt + 10'h001;
          if (r_reg.cnt == {4'h0, budget} - 10'h001) begin
            r_next.state = ST_XFER;
          end
        end
      end
      ST_XFER: begin
        r_next.cnt = 10'h000;
        if (blocked) begin
          // The discarded result still costs a full conversion.
          r_next.state = ST_SYNC;
          r_next.first = 1'b1;
        end else begin
          r_next.result_high = r_reg.mode10 ? core_s[9:8] : 2'h0;
          r_next.result_low = r_reg.mode10 ? core_s[7:0] : round8;
          r_next.conversion_complete_flag = 1'b1;
          r_next.irq = r_reg.complete_irq_enable;
          if (r_reg.continuous_enable) begin
            r_next.state = ST_CONV;
            r_next.first = 1'b0;
            r_next.start = 1'b1;
          end else begin
            r_next.state = ST_IDLE;
          end
        end
      end
      default: begin
        r_next.state = ST_IDLE;
      end
    endcase

    abort_now = wr_ctrl || wr_clk ||
                (stop_s && !r_reg.async_clock_enable && r_reg.state != ST_IDLE);
    if (abort_now) begin
      r_next.state = ST_IDLE;
      r_next.start = 1'b0;
      r_next.cnt = 10'h000;
      r_next.result_high = r_reg.result_high;
      r_next.result_low = r_reg.result_low;
      if (wr_ctrl && r_reg.w_data[CH_LSB +: CH_W] != CH_OFF && !r_reg.hw_trigger_select) begin
        r_next.state = ST_SYNC;
        r_next.first = 1'b1;
      end
    end
  end

  always_ff @(posedge MCLK_I) begin
    if (RESET_I) begin
      r_reg <= '0;
      r_reg.channel_select <= CTRL_RST[CH_LSB +: CH_W];
      r_reg.clock_divide <= CLKCFG_RST[DIV_LSB +: 2];
      r_reg.result_high <= RES_RST[9:8];
      r_reg.result_low <= RES_RST[7:0];
      r_reg.state <= ST_IDLE;
    end else begin
      r_reg <= r_next;
    end
  end

  assign AXI_BVALID_O = r_reg.bvalid;
  assign AXI_BRESP_O = r_reg.bresp;
  assign AXI_RVALID_O = r_reg.rvalid;
  assign AXI_RDATA_O = {24'h000000, r_reg.rdata};
  assign AXI_RRESP_O = r_reg.rresp;
  assign CORE_CHANNEL_O = r_reg.channel_select;
  // Power drops in the abort cycle itself, before the state register follows.
  assign CORE_POWER_O = (r_reg.state != ST_IDLE) && !abort_now;
  assign CORE_START_O = r_reg.start;
  assign IRQ_O = r_reg.irq;

  sequence s_good_xfer;
    r_reg.state == ST_XFER && !blocked && !abort_now;
  endsequence
  sequence s_flag_up;
    r_reg.conversion_complete_flag && IRQ_O == $past(r_reg.complete_irq_enable);
  endsequence

  a_one_channel: assert property (@(posedge MCLK_I) disable iff (RESET_I)
    (r_reg.state == ST_CONV && !abort_now) |=> $stable(CORE_CHANNEL_O))
    else $error("channel changed during conversion");
  a_eight_bit: assert property (@(posedge MCLK_I) disable iff (RESET_I)
    (s_good_xfer and !r_reg.mode10) |=> r_reg.result_high == 2'h0 &&
    r_reg.result_low == $past(round8)) else $error("eight-bit result wrong");
  a_sw_start: assert property (@(posedge MCLK_I) disable iff (RESET_I)
    (wr_ctrl && !r_reg.hw_trigger_select && r_reg.w_data[4:0] != CH_OFF)
    |=> r_reg.state == ST_SYNC ##3 r_reg.state != ST_SYNC)
    else $error("software start missing");
  a_ones_idle: assert property (@(posedge MCLK_I) disable iff (RESET_I)
    (wr_ctrl && r_reg.w_data[4:0] == CH_OFF) |=> r_reg.state == ST_IDLE[*2])
    else $error("all-ones channel started a conversion");
  a_clk_abort: assert property (@(posedge MCLK_I) disable iff (RESET_I)
    wr_clk |=> r_reg.state == ST_IDLE && !CORE_START_O)
    else $error("clock write did not abort");
  a_stop_abort: assert property (@(posedge MCLK_I) disable iff (RESET_I)
    (stop_s && !r_reg.async_clock_enable && r_reg.state != ST_IDLE) |-> !CORE_POWER_O
    ##1 r_reg.state == ST_IDLE) else $error("stop did not abort");
  a_flag_irq: assert property (@(posedge MCLK_I) disable iff (RESET_I)
    s_good_xfer |=> s_flag_up) else $error("flag or interrupt wrong");
  a_block_xfer: assert property (@(posedge MCLK_I) disable iff (RESET_I)
    (r_reg.state == ST_XFER && blocked && !abort_now) |=> r_reg.state == ST_SYNC &&
    $stable(r_reg.result_low) && $stable(r_reg.result_high))
    else $error("blocked transfer overwrote result");
  a_cont_next: assert property (@(posedge MCLK_I) disable iff (RESET_I)
    (s_good_xfer and r_reg.continuous_enable) |=> r_reg.state == ST_CONV && !r_reg.first)
    else $error("continuous restart missing");
  a_single_idle: assert property (@(posedge MCLK_I) disable iff (RESET_I)
    (s_good_xfer and !r_reg.continuous_enable) |=> !CORE_POWER_O)
    else $error("single conversion stayed powered");
  a_abort_keep: assert property (@(posedge MCLK_I) disable iff (RESET_I)
    abort_now |=> $stable(r_reg.result_low) && $stable(r_reg.result_high))
    else $error("abort changed result");
  a_budget_cap: assert property (@(posedge MCLK_I) disable iff (RESET_I)
    r_reg.state == ST_CONV |-> r_reg.cnt < {4'h0, budget})
    else $error("conversion ran past its budget");
  a_reset_result: assert property (@(posedge MCLK_I)
    RESET_I |=> r_reg.result_low == 8'h00 && r_reg.result_high == 2'h0)
    else $error("reset did not clear results");
endmodule

`default_nettype wire

//--- adcc_pkg.sv
`default_nettype none

package adcc_pkg;

  // Register byte offsets on the AXI4-Lite bus.
  localparam logic [3:0] OFF_CTRL = 4'h0;
  localparam logic [3:0] OFF_CLKCFG = 4'h4;
  localparam logic [3:0] OFF_RES_HI = 4'h8;
  localparam logic [3:0] OFF_RES_LO = 4'hC;

  // Status and control register fields.
  localparam int CH_LSB = 0;
  localparam int CH_W = 5;
  localparam int CONT_BIT = 5;
  localparam int IRQEN_BIT = 6;
  localparam int FLAG_BIT = 7;

  // Clock configuration register fields.
  localparam int DIV_LSB = 0;
  localparam int ICS_BIT = 2;
  localparam int LSMP_BIT = 3;
  localparam int MODE10_BIT = 4;
  localparam int ASYNC_BIT = 5;
  localparam int HWTRIG_BIT = 6;

  // Reset values.
  localparam logic [4:0] CH_OFF = 5'h1F;
  localparam logic [7:0] CTRL_RST = 8'h1F;
  localparam logic [7:0] CLKCFG_RST = 8'h00;
  localparam logic [9:0] RES_RST = 10'h000;

  // Conversion budgets in converter clocks.
  localparam logic [5:0] CCK_S8_FIRST = 6'h12;
  localparam logic [5:0] CCK_S8_NEXT = 6'h10;
  localparam logic [5:0] CCK_L8_FIRST = 6'h26;
  localparam logic [5:0] CCK_L8_NEXT = 6'h24;
  localparam logic [5:0] CCK_S10_FIRST = 6'h15;
  localparam logic [5:0] CCK_S10_NEXT = 6'h13;
  localparam logic [5:0] CCK_L10_FIRST = 6'h29;
  localparam logic [5:0] CCK_L10_NEXT = 6'h27;

  // Timing in bus clocks and nanoseconds.
  localparam logic [9:0] SYNC_BUS_CYC = 10'h003;
  localparam int CLK_PERIOD_NS = 10;
  localparam int ACLK_START_NS = 5000;
  localparam logic [9:0] ACLK_START_CYC = 10'(ACLK_START_NS / CLK_PERIOD_NS);

  // AXI responses.
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [2:0] {ST_IDLE, ST_SYNC, ST_START, ST_CONV, ST_XFER} adcc_state_t;

endpackage

`default_nettype wire

//--- adcc_sync2.sv
`timescale 1ns/1ps
`default_nettype none

module adcc_sync2 #(
  parameter int WIDTH = 1
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Data
  input wire logic [WIDTH-1:0] d_i,
  output logic [WIDTH-1:0] q_o
);
  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] stable;
  } adcc_sync_t;

  adcc_sync_t s_reg;
  adcc_sync_t s_next;

  always_comb begin
    s_next = s_reg;
    s_next.meta = d_i;
    s_next.stable = s_reg.meta;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign q_o = s_reg.stable;
endmodule

`default_nettype wire

//--- adcc_clkgen.sv
`timescale 1ns/1ps
`default_nettype none

module adcc_clkgen (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Selection
  input wire logic enable_i,
  input wire logic async_en_i,
  input wire logic ics_i,
  input wire logic [1:0] div_i,
  // Synchronised source levels
  input wire logic aclk_i,
  input wire logic altclk_i,
  // Converter clock tick
  output logic tick_o
);
  import adcc_pkg::*;

  typedef struct packed {
    logic prev;
    logic [2:0] cnt;
    logic tick;
  } adcc_cg_t;

  adcc_cg_t g_reg;
  adcc_cg_t g_next;
  logic src;
  logic edge_seen;
  logic [2:0] top;

  always_comb begin
    g_next = g_reg;
    src = async_en_i ? aclk_i : altclk_i;
    // The bus clock has an edge every cycle, so it needs no detector.
    edge_seen = (!async_en_i && ics_i) ? 1'b1 : (src && !g_reg.prev);
    top = 3'((4'h1 << div_i) - 4'h1);
    g_next.prev = src;
    g_next.tick = 1'b0;
    if (!enable_i) begin
      g_next.cnt = 3'h0;
    end else if (edge_seen) begin
      if (g_reg.cnt == top) begin
        g_next.cnt = 3'h0;
        g_next.tick = 1'b1;
      end else begin
        g_next.cnt = g_reg.cnt + 3'h1;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      g_reg <= '0;
    end else begin
      g_reg <= g_next;
    end
  end

  assign tick_o = g_reg.tick;

  a_idle_no_tick: assert property (@(posedge clk_i) disable iff (rst_i)
    !enable_i |=> !tick_o) else $error("converter clock ran while idle");
  a_bus_div_one: assert property (@(posedge clk_i) disable iff (rst_i)
    (enable_i && $past(enable_i) && !async_en_i && ics_i && div_i == 2'h0 && $stable(div_i)
     && !$past(async_en_i) && $past(ics_i)) |=> tick_o)
    else $error("divide by one of bus clock missed a tick");
endmodule

`default_nettype wire

//--- adcc_core_model.sv
`timescale 1ns/1ps
`default_nettype none

module adcc_core_model (
  // Clock
  input wire logic clk_i,
  // Control from the block
  input wire logic [4:0] channel_i,
  input wire logic power_i,
  // Raw result
  output logic [9:0] result_o
);
  logic [9:0] last_reg;

  // The code carries the channel, so a wrong input choice shows up in the result.
  always_ff @(posedge clk_i) begin
    if (power_i) begin
      last_reg <= {channel_i, 5'h0B};
    end
  end

  // An unpowered core holds nothing, so the inverse of the last code is shown.
  assign result_o = power_i ? {channel_i, 5'h0B} : ~last_reg;
endmodule

`default_nettype wire

//--- adc_conversion_control_test.sv
`timescale 1ns/1ps
`default_nettype none

module adc_conversion_control_test;
  import adcc_pkg::*;
  logic clk = 0;
  logic rst = 1;
  logic awv = 0, wv = 0, bry = 0, arv = 0, rry = 0;
  logic [3:0] awa = 0, ara = 0, ws = 4'hF;
  logic [31:0] wd = 0;
  logic acs = 0, alt = 0, trg = 0, stp = 0;
  logic awr, wrd, bv, arr, rv, pwr, stt, irq;
  logic [1:0] br, rr, rsp;
  logic [31:0] rdat, q;
  logic [9:0] res;
  logic [4:0] chn;
  int err_total = 0;
  int tests_run = 0;
  int first_c[4] = '{18, 38, 21, 41};
  int next_c[4] = '{16, 36, 19, 39};

  always #5 clk = ~clk;
  // Both slow sources change on falling bus edges only.
  always #40 acs = ~acs;
  always #30 alt = ~alt;

  adcc_top i_dut (.MCLK_I(clk), .RESET_I(rst), .AXI_AWVALID_I(awv), .AXI_AWREADY_O(awr),
    .AXI_AWADDR_I(awa), .AXI_WVALID_I(wv), .AXI_WREADY_O(wrd), .AXI_WDATA_I(wd),
    .AXI_WSTRB_I(ws), .AXI_BVALID_O(bv), .AXI_BREADY_I(bry), .AXI_BRESP_O(br),
    .AXI_ARVALID_I(arv), .AXI_ARREADY_O(arr), .AXI_ARADDR_I(ara), .AXI_RVALID_O(rv),
    .AXI_RREADY_I(rry), .AXI_RDATA_O(rdat), .AXI_RRESP_O(rr), .ACLK_SRC_I(acs),
    .ALTCLK_SRC_I(alt), .HW_TRIGGER_I(trg), .STOP_MODE_I(stp), .CORE_RESULT_I(res),
    .CORE_CHANNEL_O(chn), .CORE_POWER_O(pwr), .CORE_START_O(stt), .IRQ_O(irq));

  adcc_core_model i_core (.clk_i(clk), .channel_i(chn), .power_i(pwr), .result_o(res));

  task stop_test;
    $display("checks %0d, mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      err_total++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask

  task chk_n(input string nm, input int n, input int lo, input int hi);
    tests_run++;
    if (n < lo || n > hi) begin
      err_total++;
      $display("mismatch %s expected %0d..%0d seen %0d", nm, lo, hi, n);
    end
  endtask

  // Readiness is sampled between edges, where it is settled, to decide the next edge.
  task wr(input logic [3:0] a, input logic [7:0] d);
    logic ta, tw, done;
    @(posedge clk);
    awv <= 1;
    wv <= 1;
    bry <= 1;
    awa <= a;
    wd <= {24'h0, d};
    ta = 0;
    tw = 0;
    done = 0;
    while (!done) begin
      @(negedge clk);
      ta = ta | (awv && awr === 1'b1);
      tw = tw | (wv && wrd === 1'b1);
      done = bv === 1'b1;
      rsp = br;
      @(posedge clk);
      if (ta) awv <= 0;
      if (tw) wv <= 0;
    end
    bry <= 0;
  endtask

  task rd(input logic [3:0] a);
    logic t, done;
    @(posedge clk);
    arv <= 1;
    rry <= 1;
    ara <= a;
    t = 0;
    done = 0;
    while (!done) begin
      @(negedge clk);
      t = t | (arv && arr === 1'b1);
      done = rv === 1'b1;
      q = rdat;
      rsp = rr;
      @(posedge clk);
      if (t) arv <= 0;
    end
    rry <= 0;
  endtask

  task wirq(input int lo, input int hi);
    int n;
    n = 0;
    while (irq !== 1'b1 && n < 3000) begin
      @(negedge clk);
      n++;
    end
    chk_n("cycles", n, lo, hi);
  endtask

  task conv(input logic [7:0] cfg, input logic [7:0] ctl, input int lo, input int hi);
    wr(OFF_CLKCFG, cfg);
    wr(OFF_CTRL, ctl);
    // Results are read only after completion, so no conversion is discarded.
    wirq(lo, hi);
  endtask

  initial begin
    repeat (20000) @(posedge clk);
    err_total++;
    stop_test;
  end

  initial begin
    int n;
    repeat (16) @(posedge clk);
    rst <= 0;
    rd(OFF_CTRL);
    chk("ctrl", {24'h0, CTRL_RST}, q);
    rd(OFF_CLKCFG);
    chk("clkcfg", {24'h0, CLKCFG_RST}, q);
    rd(OFF_RES_HI);
    chk("res hi", 32'h0, q);
    rd(OFF_RES_LO);
    chk("res lo", 32'h0, q);
    rd(4'h2);
    chk("rresp", {30'h0, RESP_SLVERR}, {30'h0, rsp});
    wr(4'h2, 8'h00);
    chk("bresp", {30'h0, RESP_SLVERR}, {30'h0, rsp});
    wr(OFF_CTRL, 8'h5F);
    chk("bresp", {30'h0, RESP_OKAY}, {30'h0, rsp});
    repeat (40) @(negedge clk);
    chk("power", 32'h0, {31'h0, pwr});
    // Modes in order 8 short, 8 long, 10 short, 10 long.
    for (int m = 0; m < 4; m++) begin
      conv({3'h0, m[1], m[0], 3'h4}, 8'h6B,
           first_c[m] - 1, first_c[m] + 9);
      n = 0;
      while (stt !== 1'b1 && n < 200) begin
        @(negedge clk);
        n++;
      end
      n = 0;
      do begin
        @(negedge clk);
        n++;
      end while (stt !== 1'b1 && n < 200);
      chk_n("gap", n, next_c[m] - 1, next_c[m] + 2);
      wr(OFF_CTRL, 8'h1F);
      chk("power", 32'h0, {31'h0, pwr});
      rd(OFF_RES_HI);
      chk("res hi", m[1] ? 32'h1 : 32'h0, q);
      rd(OFF_RES_LO);
      chk("res lo", m[1] ? 32'h6B : 32'h5B, q);
      chk("irq", 32'h0, {31'h0, irq});
    end
    wr(OFF_CLKCFG, 8'h14);
    wr(OFF_CTRL, 8'h0B);
    repeat (60) @(negedge clk);
    rd(OFF_CTRL);
    chk("ctrl", 32'h8B, q);
    chk("irq", 32'h0, {31'h0, irq});
    chk("power", 32'h0, {31'h0, pwr});
    // A half-read result must block the new one.
    wr(OFF_CTRL, 8'h46);
    rd(OFF_RES_HI);
    chk("res hi", 32'h1, q);
    repeat (80) @(negedge clk);
    chk("irq", 32'h0, {31'h0, irq});
    chk("power", 32'h1, {31'h0, pwr});
    rd(OFF_RES_LO);
    chk("res lo", 32'h6B, q);
    wirq(0, 40);
    rd(OFF_RES_HI);
    chk("res hi", 32'h0, q);
    rd(OFF_RES_LO);
    chk("res lo", 32'hCB, q);
    wr(OFF_CTRL, 8'h51);
    repeat (8) @(negedge clk);
    chk("power", 32'h1, {31'h0, pwr});
    wr(OFF_CLKCFG, 8'h14);
    chk("power", 32'h0, {31'h0, pwr});
    repeat (60) @(negedge clk);
    chk("irq", 32'h0, {31'h0, irq});
    rd(OFF_RES_LO);
    chk("res lo", 32'hCB, q);
    wr(OFF_CTRL, 8'h51);
    repeat (8) @(negedge clk);
    chk("power", 32'h1, {31'h0, pwr});
    @(posedge clk);
    stp <= 1;
    repeat (4) @(posedge clk);
    stp <= 0;
    @(negedge clk);
    chk("power", 32'h0, {31'h0, pwr});
    repeat (60) @(negedge clk);
    chk("irq", 32'h0, {31'h0, irq});
    wr(OFF_CLKCFG, 8'h54);
    wr(OFF_CTRL, 8'h51);
    repeat (40) @(negedge clk);
    chk("irq", 32'h0, {31'h0, irq});
    @(posedge clk);
    trg <= 1;
    repeat (4) @(posedge clk);
    trg <= 0;
    wirq(0, 40);
    rd(OFF_RES_LO);
    chk("res lo", 32'h2B, q);
    conv(8'h07, 8'h45, 17 * 8, 18 * 8 + 19);
    conv(8'h00, 8'h45, 17 * 6, 18 * 6 + 19);
    conv(8'h20, 8'h45, 17 * 8, 18 * 8 + 519);
    rd(OFF_RES_LO);
    chk("res lo", 32'h2B, q);
    // A reset in the middle of a conversion must clear the kept result.
    wr(OFF_CTRL, 8'h45);
    @(negedge clk);
    chk("power", 32'h1, {31'h0, pwr});
    @(posedge clk);
    rst <= 1;
    repeat (16) @(posedge clk);
    rst <= 0;
    @(negedge clk);
    chk("power", 32'h0, {31'h0, pwr});
    rd(OFF_RES_LO);
    chk("res lo", 32'h0, q);
    rd(OFF_CTRL);
    chk("ctrl", {24'h0, CTRL_RST}, q);
    stop_test;
  end
endmodule

`default_nettype wire
